// File: inc/rtc_alarm_consts.svh
`ifndef RTC_ALARM_CONSTS_SVH
`define RTC_ALARM_CONSTS_SVH

// register addresses on the serial bus
`define ADDR_WEEKLY_ALARM_HOUR 4'h9
`define ADDR_WEEKLY_ALARM_WEEKDAYS 4'hA
`define ADDR_DAILY_ALARM_MINUTE 4'hB
`define ADDR_DAILY_ALARM_HOUR 4'hC

// writable field masks, everything above reads zero
`define MASK_HOUR 8'h3F
`define MASK_WEEKDAYS 8'h7F
`define MASK_MINUTE 8'h7F

// hour field layout
`define HOUR_UPPER_BIT 5
`define HOUR_TENS_BIT 4

// 12-hour encodings of midnight and noon
`define HOUR12_MIDNIGHT 6'h12
`define HOUR12_NOON 6'h32

// weekday counter range
`define WEEKDAY_FIRST 3'h0
`define WEEKDAY_LAST 3'h6

// address pointer value after a stop
`define POINTER_IDLE 4'hF

// alarm reset values
`define ALARM_HOUR_RESET 6'h00
`define ALARM_WEEKDAYS_RESET 7'h00
`define ALARM_MINUTE_RESET 7'h00

`endif

// File: inc/rtc_alarm_pkg.sv
package rtc_alarm_pkg;

    typedef struct packed {
        logic [6:0] weekly_minute;
        logic [5:0] weekly_hour;
        logic [6:0] weekdays;
        logic [6:0] daily_minute;
        logic [5:0] daily_hour;
    } alarm_cfg_t;

    typedef struct packed {
        logic [6:0] minute;
        logic [5:0] hour;
        logic day_carry;
    } running_time_t;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'b000,
        BUS_ADDR = 3'b001,
        BUS_ACK = 3'b010,
        BUS_RX = 3'b011,
        BUS_TX = 3'b100,
        BUS_MACK = 3'b101
    } bus_state_t;

endpackage

// File: core/rtc_dual_alarm_registers.sv
`include "rtc_alarm_consts.svh"

// How it works
// R1: weekly hour at 9h holds six BCD bits; bits 7 and 6 read zero.
// R2: weekday register at Ah holds seven enable bits; bit 7 reads zero.
// R3: daily minute at Bh holds BCD tens and units; bit 7 reads zero.
// R4: daily hour at Ch holds six BCD bits; bits 7 and 6 read zero.
// R5: weekly hour bit 5 is afternoon flag or twenties digit, stored as written.
// R6: daily hour bit 5 plays the same double role, stored as written.
// R7: midnight is 12 and noon is 32 in 12-hour mode.
// R8: each enable bit matches one weekday code 0 to 6.
// R9: with no weekday enabled the weekly alarm never fires.
// R10: host must not load impossible times; those simply never match.
// R11: after oscillation stop alarm fields are undefined; reserved bits still zero.
// R12: bus outputs only pull low, never drive high.
// R13: weekday counter steps once a day 0 to 6 and wraps.
// R14: alarm fires on equal minute and hour, weekly also on enabled weekday.
module rtc_dual_alarm_registers #(
    parameter logic [6:0] SLAVE_ADDRESS = 7'h2A  // arbitrary value
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic [6:0] weekly_alarm_minute,
    input wire logic rtc_clk,
    input wire rtc_alarm_pkg::running_time_t running_time,
    output logic [2:0] weekday,
    output logic weekly_alarm_match,
    output logic daily_alarm_match
);
    import rtc_alarm_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic scl_meta, scl_sync, scl_prev;
    logic sda_meta, sda_sync, sda_prev;

    always_ff @(posedge clk) begin
        if (rst) begin
            scl_meta <= 1'b1;
            scl_sync <= 1'b1;
            scl_prev <= 1'b1;
            sda_meta <= 1'b1;
            sda_sync <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            scl_meta <= scl_in;
            scl_sync <= scl_meta;
            scl_prev <= scl_sync;
            sda_meta <= sda_in;
            sda_sync <= sda_meta;
            sda_prev <= sda_sync;
        end
    end

    logic scl_rise, scl_fall, bus_start, bus_stop;
    assign scl_rise = scl_sync && !scl_prev;
    assign scl_fall = !scl_sync && scl_prev;
    assign bus_start = scl_sync && scl_prev && sda_prev && !sda_sync;
    assign bus_stop = scl_sync && scl_prev && !sda_prev && sda_sync;

    ////////////////////////////////////////////////////////////////////////
    // alarm registers

    logic [5:0] weekly_hour;
    logic [6:0] weekdays;
    logic [6:0] daily_minute;
    logic [5:0] daily_hour;
    logic [3:0] pointer;
    logic reg_write;
    logic [7:0] rx_byte;

    // reset gives defined values although software must treat them as unknown
    always_ff @(posedge clk) begin
        if (rst) begin
            weekly_hour <= `ALARM_HOUR_RESET;
            weekdays <= `ALARM_WEEKDAYS_RESET;
            daily_minute <= `ALARM_MINUTE_RESET;
            daily_hour <= `ALARM_HOUR_RESET;
        end else if (reg_write) begin
            case (pointer)
                `ADDR_WEEKLY_ALARM_HOUR: begin
                    weekly_hour <= rx_byte[5:0]; // R1 R5 R7
                end
                `ADDR_WEEKLY_ALARM_WEEKDAYS: begin
                    weekdays <= rx_byte[6:0]; // R2
                end
                `ADDR_DAILY_ALARM_MINUTE: begin
                    daily_minute <= rx_byte[6:0]; // R3
                end
                `ADDR_DAILY_ALARM_HOUR: begin
                    daily_hour <= rx_byte[5:0]; // R4 R6 R7
                end
                default: begin
                end
            endcase
        end
    end

    logic [7:0] read_data;

    // upper bits come back zero whatever was written or lost
    always_comb begin
        case (pointer)
            `ADDR_WEEKLY_ALARM_HOUR: read_data = {2'h0, weekly_hour} & `MASK_HOUR; // R1 R11
            `ADDR_WEEKLY_ALARM_WEEKDAYS: read_data = {1'h0, weekdays} & `MASK_WEEKDAYS; // R2 R11
            `ADDR_DAILY_ALARM_MINUTE: read_data = {1'h0, daily_minute} & `MASK_MINUTE; // R3 R11
            `ADDR_DAILY_ALARM_HOUR: read_data = {2'h0, daily_hour} & `MASK_HOUR; // R4 R11
            default: read_data = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // serial bus slave

    bus_state_t state;
    logic [3:0] bit_count;
    logic [7:0] shift;
    logic read_mode;
    logic first_byte;
    logic master_nack;

    assign sda_out = 1'b0; // R12

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= BUS_IDLE;
            bit_count <= 4'h0;
            shift <= 8'h00;
            read_mode <= 1'b0;
            first_byte <= 1'b0;
            master_nack <= 1'b0;
            pointer <= `POINTER_IDLE;
            sda_oe_n <= 1'b1;
            reg_write <= 1'b0;
            rx_byte <= 8'h00;
        end else begin
            reg_write <= 1'b0;
            if (bus_stop) begin
                state <= BUS_IDLE;
                pointer <= `POINTER_IDLE;
                sda_oe_n <= 1'b1;
            end else if (bus_start) begin
                state <= BUS_ADDR;
                bit_count <= 4'h0;
                sda_oe_n <= 1'b1;
            end else begin
                case (state)
                    BUS_IDLE: begin
                        sda_oe_n <= 1'b1;
                    end
                    BUS_ADDR: begin
                        if (scl_rise) begin
                            shift <= {shift[6:0], sda_sync};
                            bit_count <= bit_count + 4'h1;
                        end else if (scl_fall && bit_count == 4'h8) begin
                            if (shift[7:1] == SLAVE_ADDRESS) begin
                                read_mode <= shift[0];
                                first_byte <= 1'b1;
                                sda_oe_n <= 1'b0; // R12
                                state <= BUS_ACK;
                            end else begin
                                state <= BUS_IDLE;
                            end
                        end
                    end
                    BUS_ACK: begin
                        if (scl_fall) begin
                            bit_count <= 4'h0;
                            if (read_mode) begin
                                shift <= read_data;
                                sda_oe_n <= read_data[7]; // R12
                                pointer <= pointer + 4'h1;
                                state <= BUS_TX;
                            end else begin
                                sda_oe_n <= 1'b1;
                                state <= BUS_RX;
                            end
                        end
                    end
                    BUS_RX: begin
                        if (scl_rise) begin
                            shift <= {shift[6:0], sda_sync};
                            bit_count <= bit_count + 4'h1;
                        end else if (scl_fall && bit_count == 4'h8) begin
                            if (first_byte) begin
                                // low nibble selects transfer format, only plain format kept
                                pointer <= shift[7:4];
                                first_byte <= 1'b0;
                            end else begin
                                rx_byte <= shift;
                                reg_write <= 1'b1;
                            end
                            sda_oe_n <= 1'b0;
                            state <= BUS_ACK;
                        end
                    end
                    BUS_TX: begin
                        if (scl_rise) begin
                            bit_count <= bit_count + 4'h1;
                        end else if (scl_fall) begin
                            if (bit_count == 4'h8) begin
                                sda_oe_n <= 1'b1;
                                state <= BUS_MACK;
                            end else begin
                                shift <= {shift[6:0], 1'b0};
                                sda_oe_n <= shift[6]; // R12
                            end
                        end
                    end
                    BUS_MACK: begin
                        if (scl_rise) begin
                            master_nack <= sda_sync;
                        end else if (scl_fall) begin
                            if (master_nack) begin
                                state <= BUS_IDLE;
                            end else begin
                                bit_count <= 4'h0;
                                shift <= read_data;
                                sda_oe_n <= read_data[7];
                                pointer <= pointer + 4'h1;
                                state <= BUS_TX;
                            end
                        end
                    end
                    default: begin
                        state <= BUS_IDLE;
                        sda_oe_n <= 1'b1;
                    end
                endcase
            end
        end
    end

    // a landed write marks the settings for the next hand-over
    logic write_step;
    assign write_step = reg_write;

    ////////////////////////////////////////////////////////////////////////
    // settings handed to the timekeeping domain by req/ack handshake

    alarm_cfg_t cfg_now, cfg_hold;
    logic dirty, req, ack_meta, ack_sync, busy, rtc_ack;
    logic minute_prev_changed;
    logic [6:0] weekly_minute_prev;

    assign cfg_now = '{weekly_minute: weekly_alarm_minute, weekly_hour: weekly_hour,
                       weekdays: weekdays, daily_minute: daily_minute, daily_hour: daily_hour};
    assign busy = req != ack_sync;
    assign minute_prev_changed = weekly_minute_prev != weekly_alarm_minute;

    always_ff @(posedge clk) begin
        if (rst) begin
            dirty <= 1'b1;
            req <= 1'b0;
            ack_meta <= 1'b0;
            ack_sync <= 1'b0;
            cfg_hold <= '0;
            weekly_minute_prev <= 7'h00;
        end else begin
            ack_meta <= rtc_ack;
            ack_sync <= ack_meta;
            weekly_minute_prev <= weekly_alarm_minute;
            if (!busy && dirty) begin
                cfg_hold <= cfg_now;
                req <= !req;
            end
            // a new write in the launch cycle keeps the flag set
            if (write_step || minute_prev_changed) begin
                dirty <= 1'b1;
            end else if (!busy && dirty) begin
                dirty <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // timekeeping domain

    logic rtc_rst_meta, rtc_rst;
    logic req_meta, req_sync, req_prev;
    alarm_cfg_t cfg_rtc;

    always_ff @(posedge rtc_clk) begin
        rtc_rst_meta <= rst;
        rtc_rst <= rtc_rst_meta;
    end

    always_ff @(posedge rtc_clk) begin
        if (rtc_rst) begin
            req_meta <= 1'b0;
            req_sync <= 1'b0;
            req_prev <= 1'b0;
            rtc_ack <= 1'b0;
            cfg_rtc <= '0;
        end else begin
            req_meta <= req;
            req_sync <= req_meta;
            req_prev <= req_sync;
            if (req_sync != req_prev) begin
                cfg_rtc <= cfg_hold;
                rtc_ack <= req_sync;
            end
        end
    end

    always_ff @(posedge rtc_clk) begin
        if (rtc_rst) begin
            weekday <= `WEEKDAY_FIRST;
        end else if (running_time.day_carry) begin
            if (weekday >= `WEEKDAY_LAST) begin
                weekday <= `WEEKDAY_FIRST; // R13
            end else begin
                weekday <= weekday + 3'h1; // R13
            end
        end
    end

    logic day_enabled;
    // code 7 has no enable bit, so it never matches
    assign day_enabled = (weekday <= `WEEKDAY_LAST) && cfg_rtc.weekdays[weekday]; // R8 R9

    // raw compare: an impossible stored time just never matches
    always_ff @(posedge rtc_clk) begin
        if (rtc_rst) begin
            weekly_alarm_match <= 1'b0;
            daily_alarm_match <= 1'b0;
        end else begin
            weekly_alarm_match <= day_enabled && running_time.hour == cfg_rtc.weekly_hour
                                  && running_time.minute == cfg_rtc.weekly_minute; // R14 R5 R10
            daily_alarm_match <= running_time.hour == cfg_rtc.daily_hour
                                 && running_time.minute == cfg_rtc.daily_minute; // R14 R6 R10
        end
    end

endmodule

// File: test/rtc_alarm_chk.sv
module rtc_alarm_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic [6:0] weekly_alarm_minute,
    input wire logic rtc_clk,
    input wire rtc_alarm_pkg::running_time_t running_time,
    input wire logic [2:0] weekday,
    input wire logic weekly_alarm_match,
    input wire logic daily_alarm_match
);
    timeunit 1ns;
    timeprecision 100ps;
    import rtc_alarm_pkg::*;
    // slow side takes reset through its own synchroniser; stay quiet four of its edges longer
    logic [3:0] rtc_rst_hist;
    logic rtc_quiet;
    always_ff @(posedge rtc_clk) begin
        rtc_rst_hist <= {rtc_rst_hist[2:0], rst};
    end
    assign rtc_quiet = rst || rtc_rst_hist != 4'h0;
    ////////////////////////////////////////
    chk_pull_low_only: assert property (@(posedge clk) sda_out == 1'b0)
        else $error("sda_out high");
    chk_reset_release: assert property (@(posedge clk) rst |=> sda_oe_n)
        else $error("sda held in reset");
    chk_take_scl_low: assert property (@(posedge clk) disable iff (rst) $fell(sda_oe_n) |-> !scl_in)
        else $error("sda taken with scl high");
    chk_free_scl_low: assert property (@(posedge clk) disable iff (rst) $rose(sda_oe_n) |-> !scl_in)
        else $error("sda freed with scl high");
    chk_weekday_range: assert property (@(posedge rtc_clk) disable iff (rtc_quiet) weekday <= 3'h6)
        else $error("weekday out of range");
    chk_weekday_step: assert property (@(posedge rtc_clk) disable iff (rtc_quiet)
        running_time.day_carry && weekday != 3'h6 |=> weekday == $past(weekday) + 3'h1)
        else $error("weekday did not step");
    chk_weekday_wrap: assert property (@(posedge rtc_clk) disable iff (rtc_quiet)
        running_time.day_carry && weekday == 3'h6 |=> weekday == 3'h0)
        else $error("weekday did not wrap");
    chk_weekday_hold: assert property (@(posedge rtc_clk) disable iff (rtc_quiet)
        !running_time.day_carry |=> $stable(weekday))
        else $error("weekday moved without carry");
    cover property (@(posedge clk) $fell(sda_oe_n));
    cover property (@(posedge rtc_clk) $rose(daily_alarm_match));
    cover property (@(posedge rtc_clk) $rose(weekly_alarm_match));
    cover property (@(posedge rtc_clk) running_time.day_carry && weekday == 3'h6);
endmodule

bind rtc_dual_alarm_registers rtc_alarm_chk chk (.clk(clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .weekly_alarm_minute(weekly_alarm_minute), .rtc_clk(rtc_clk),
    .running_time(running_time), .weekday(weekday), .weekly_alarm_match(weekly_alarm_match),
    .daily_alarm_match(daily_alarm_match));

// File: test/i2c_host_model.sv
module i2c_host_model (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_drv
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // data moves only mid-low, well clear of the device's sync lag
    task automatic put_bit(input logic b, output logic got);
        sda_drv <= b;
        tick(10);
        scl <= 1'b1;
        tick(10);
        got = sda;
        scl <= 1'b0;
        tick(5);
    endtask
    task automatic start();
        sda_drv <= 1'b1;
        tick(8);
        scl <= 1'b1;
        tick(10);
        sda_drv <= 1'b0;
        tick(10);
        scl <= 1'b0;
        tick(5);
    endtask
    task automatic stop();
        sda_drv <= 1'b0;
        tick(8);
        scl <= 1'b1;
        tick(10);
        sda_drv <= 1'b1;
        tick(10);
    endtask
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--)
            put_bit(d[i], g);
        put_bit(1'b1, g);
        ack = ~g;
    endtask
    // callers load only times that can occur
    task automatic write_reg(input logic [6:0] dev, input logic [3:0] a, input logic [7:0] d, output logic ok);
        logic a1, a2, a3;
        start();
        send_byte({dev, 1'b0}, a1);
        send_byte({a, 4'h0}, a2);
        send_byte(d, a3);
        stop();
        ok = a1 & a2 & a3;
    endtask
    task automatic read_reg(input logic [6:0] dev, input logic [3:0] a, output logic [7:0] d);
        logic g;
        start();
        send_byte({dev, 1'b0}, g);
        send_byte({a, 4'h0}, g);
        start();
        send_byte({dev, 1'b1}, g);
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, g);
            d[i] = g;
        end
        put_bit(1'b1, g);
        stop();
    endtask
    // master acks the first byte so the device moves on to the next register
    task automatic read_pair(input logic [6:0] dev, input logic [3:0] a, output logic [15:0] d);
        logic g;
        start();
        send_byte({dev, 1'b0}, g);
        send_byte({a, 4'h0}, g);
        start();
        send_byte({dev, 1'b1}, g);
        for (int i = 15; i >= 0; i--) begin
            put_bit(1'b1, g);
            d[i] = g;
            if (i == 8)
                put_bit(1'b0, g);
        end
        put_bit(1'b1, g);
        stop();
    endtask
endmodule

// File: test/rtc_dual_alarm_registers_bench.sv
module rtc_dual_alarm_registers_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import rtc_alarm_pkg::*;
    localparam logic [6:0] DEV = 7'h2A;  // arbitrary value
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic rtc_clk = 1'b0;
    logic scl;
    logic host_sda;
    wire sda_line;
    logic sda_out;
    logic sda_oe_n;
    logic [6:0] weekly_alarm_minute = 7'h00;
    running_time_t running_time = '0;
    logic [2:0] weekday;
    logic weekly_alarm_match;
    logic daily_alarm_match;
    logic [2:0] exp_day = 3'h0;
    int n_fail = 0;
    int total_checks = 0;
    always #5 clk = ~clk;
    initial begin
        #3.3;
        forever #62.5 rtc_clk = ~rtc_clk;
    end
    assign sda_line = host_sda & (sda_oe_n | sda_out);
    rtc_dual_alarm_registers #(.SLAVE_ADDRESS(DEV)) dut (.clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .weekly_alarm_minute(weekly_alarm_minute), .rtc_clk(rtc_clk),
        .running_time(running_time), .weekday(weekday), .weekly_alarm_match(weekly_alarm_match),
        .daily_alarm_match(daily_alarm_match));
    i2c_host_model host (.clk(clk), .sda(sda_line), .scl(scl), .sda_drv(host_sda));
    ////////////////////////////////////////
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        check_byte({7'h00, got}, {7'h00, exp});
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic ok;
        host.write_reg(DEV, a, d, ok);
        if (a inside {[4'h9:4'hC]})
            check_bit(ok, 1'b1);
    endtask
    task automatic rd_check(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.read_reg(DEV, a, d);
        check_byte(d, exp);
    endtask
    // crossing into the slow domain takes a few of its edges
    task automatic set_time(input logic [6:0] m, input logic [5:0] h);
        @(posedge rtc_clk);
        running_time.minute <= m;
        running_time.hour <= h;
        repeat (6) @(posedge rtc_clk);
    endtask
    task automatic day_walk(input logic [6:0] en);
        for (int i = 0; i < 8; i++) begin
            check_byte({5'h00, weekday}, {5'h00, exp_day});
            check_bit(weekly_alarm_match, en[exp_day]);
            @(posedge rtc_clk) running_time.day_carry <= 1'b1;
            @(posedge rtc_clk) running_time.day_carry <= 1'b0;
            repeat (3) @(posedge rtc_clk);
            exp_day = (exp_day == 3'h6) ? 3'h0 : exp_day + 3'h1;
        end
    endtask
    ////////////////////////////////////////
    task automatic t_regs();
        logic [3:0] addr [5];
        logic [7:0] val [5];
        logic [7:0] exp [5];
        addr = '{4'h9, 4'hA, 4'hB, 4'hC, 4'hD};
        val = '{8'hE3, 8'hFF, 8'hD9, 8'hD2, 8'hFF};
        exp = '{8'h23, 8'h7F, 8'h59, 8'h12, 8'h00};
        for (int i = 0; i < 5; i++) begin
            rd_check(addr[i], 8'h00);
            wr(addr[i], val[i]);
            rd_check(addr[i], exp[i]);
        end
    endtask
    task automatic t_wrong_addr();
        logic ok;
        host.write_reg(DEV ^ 7'h01, 4'h9, 8'h11, ok);
        check_bit(ok, 1'b0);
        rd_check(4'h9, 8'h23);
    endtask
    task automatic t_daily();
        logic [15:0] pair;
        wr(4'hB, 8'h30);
        wr(4'hC, 8'h32);
        host.read_pair(DEV, 4'hB, pair);
        check_byte(pair[15:8], 8'h30);
        check_byte(pair[7:0], 8'h32);
        set_time(7'h30, 6'h12);
        check_bit(daily_alarm_match, 1'b0);
        set_time(7'h30, 6'h32);
        check_bit(daily_alarm_match, 1'b1);
        set_time(7'h31, 6'h32);
        check_bit(daily_alarm_match, 1'b0);
    endtask
    task automatic t_weekly();
        @(posedge clk) weekly_alarm_minute <= 7'h59;
        wr(4'h9, 8'h23);
        wr(4'hA, 8'h00);
        set_time(7'h59, 6'h23);
        day_walk(7'h00);
        wr(4'hA, 8'h2A);
        set_time(7'h59, 6'h23);
        day_walk(7'h2A);
    endtask
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        // slow side re-syncs this reset and leaves it a few of its edges later
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (5) @(posedge clk);
        t_regs();
        t_wrong_addr();
        t_daily();
        t_weekly();
        print_verdict();
    end
    initial begin
        repeat (90000) @(posedge clk);
        n_fail++;
        print_verdict();
    end
endmodule
